// [rtl/sdi_defs.vh]
// constants for the sdram init tracker and mode word decoder
//
// Contract
// - precharge-all then only nops for precharge_time
// - mode word loaded before operation, then kept
// - mode-set counts only with bank bits zero
// - data outputs high impedance after mode-set
// - mode word field positions decoded
// - lengths one two four eight full page
// - fixed bursts wrap inside aligned block
// - column address bits chosen per width
// - full page steps and wraps whole row
// - sequential adds index, interleaved xors index
// - burst_order_bit selects the ordering
// - length one ignores order, exact column
// - read latency two or three clocks
// - full page runs until burst terminate
// - op mode bits zero means normal
// - write_burst_option_bit forces single writes
`ifndef SDI_DEFS_VH
`define SDI_DEFS_VH

// command codes on {ras_n, cas_n, we_n}
`define SDI_CMD_MODE_SET 3'h0
`define SDI_CMD_REFRESH 3'h1
`define SDI_CMD_PRECHARGE 3'h2
`define SDI_CMD_ACTIVE 3'h3
`define SDI_CMD_WRITE 3'h4
`define SDI_CMD_READ 3'h5
`define SDI_CMD_TERMINATE 3'h6
`define SDI_CMD_NOP 3'h7

// device organisation: 0 by-4, 1 by-8, 2 by-16
`define SDI_ORG 2'h1

// timing
`define SDI_CLK_PERIOD_NS 100
`define SDI_POWERUP_NS 100000
`define SDI_PRECHARGE_NS 20
`define SDI_REFRESH_NS 70
`define SDI_MODE_SET_NS 20
`define SDI_CYC(ns) (((ns) + `SDI_CLK_PERIOD_NS - 1) / `SDI_CLK_PERIOD_NS)
`define SDI_POWERUP_CYC `SDI_CYC(`SDI_POWERUP_NS)
`define SDI_PRECHARGE_CYC `SDI_CYC(`SDI_PRECHARGE_NS)
`define SDI_REFRESH_CYC `SDI_CYC(`SDI_REFRESH_NS)
`define SDI_MODE_SET_CYC `SDI_CYC(`SDI_MODE_SET_NS)
`define SDI_MIN_REFRESHES 4'h2

// mode word fields
`define SDI_MODE_BL_LO 0
`define SDI_MODE_BL_HI 2
`define SDI_MODE_ORDER 3
`define SDI_MODE_LAT_LO 4
`define SDI_MODE_LAT_HI 6
`define SDI_MODE_OP_LO 7
`define SDI_MODE_OP_HI 8
`define SDI_MODE_WBO 9
`define SDI_MODE_RESET 12'h000

`define SDI_BL_1 3'h0
`define SDI_BL_2 3'h1
`define SDI_BL_4 3'h2
`define SDI_BL_8 3'h3
`define SDI_BL_PAGE 3'h7
`define SDI_LAT_2 3'h2
`define SDI_LAT_3 3'h3

// register map
`define SDI_REG_STATUS 8'h00
`define SDI_REG_MODE 8'h04
`define SDI_REG_CTRL 8'h08
`define SDI_CTRL_ENFORCE 0
`define SDI_CTRL_CLEAR 1
`define SDI_CTRL_RESET 1'h0

`endif

// [rtl/sdi_init_mode.v]
// sdram power-up sequence tracker, mode word and burst column sequencer
`timescale 1ns/1ps
`include "sdi_defs.vh"

module sdi_init_mode (
    input wire CLK_I,
    input wire RESET_N_I,
    input wire CKE_I,
    input wire CS_N_I,
    input wire RAS_N_I,
    input wire CAS_N_I,
    input wire WE_N_I,
    input wire [1:0] BA_I,
    input wire [11:0] ADDR_I,
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [7:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    output wire [31:0] PRDATA_O,
    output wire PREADY_O,
    output wire PSLVERR_O,
    output wire [10:0] COL_ADDR_O,
    output wire COL_VALID_O,
    output wire COL_WRITE_O,
    output wire DQ_OE_O,
    output wire INIT_DONE_O
);

    localparam PH_POWER = 2'h0;
    localparam PH_PRECHARGE = 2'h1;
    localparam PH_IDLE = 2'h2;
    localparam PH_READY = 2'h3;
    localparam integer PWR_I = `SDI_POWERUP_CYC, PRE_I = `SDI_PRECHARGE_CYC;
    localparam integer REF_I = `SDI_REFRESH_CYC, MSET_I = `SDI_MODE_SET_CYC;
    localparam [11:0] PWR_CYC = PWR_I[11:0];
    localparam [2:0] PRE_CYC = PRE_I[2:0];
    localparam [2:0] REF_CYC = REF_I[2:0];
    localparam [2:0] MSET_CYC = MSET_I[2:0];
    localparam [10:0] PAGE_MASK = (`SDI_ORG == 2'h0) ? 11'h7FF :
                                  (`SDI_ORG == 2'h1) ? 11'h3FF : 11'h1FF;

    reg [1:0] phase_reg, phase_next;
    reg [11:0] pw_cnt_reg, pw_cnt_next;
    reg seen_nop_reg, seen_nop_next;
    reg [2:0] busy_reg, busy_next;
    reg [3:0] ref_cnt_reg, ref_cnt_next;
    reg loaded_reg, loaded_next;
    reg [11:0] mode_reg, mode_next;
    reg viol_reg, viol_next;
    reg mode_err_reg, mode_err_next;
    reg enforce_reg, enforce_next;
    reg active_reg, active_next;
    reg is_read_reg, is_read_next;
    reg full_reg, full_next;
    reg inter_reg, inter_next;
    reg [10:0] start_reg, start_next;
    reg [10:0] mask_reg, mask_next;
    reg [10:0] idx_reg, idx_next;
    reg [10:0] col_reg, col_next;
    reg col_valid_reg, col_valid_next;
    reg col_write_reg, col_write_next;
    reg rd_beat_reg, rd_beat_next;
    reg rd_pipe_reg, rd_pipe_next;
    reg dq_oe_reg, dq_oe_next;
    reg done_reg, done_next;
    reg [31:0] prdata_reg, prdata_next;
    reg pready_reg, pready_next;
    reg pslverr_reg, pslverr_next;

    wire cmd_en = CKE_I & ~CS_N_I;
    wire [2:0] cmd = {RAS_N_I, CAS_N_I, WE_N_I};
    wire is_nop = ~cmd_en | (cmd == `SDI_CMD_NOP);
    wire is_pre_all = cmd_en & (cmd == `SDI_CMD_PRECHARGE) & ADDR_I[10];
    wire is_pre = cmd_en & (cmd == `SDI_CMD_PRECHARGE);
    wire is_refresh = cmd_en & (cmd == `SDI_CMD_REFRESH);
    wire is_mset = cmd_en & (cmd == `SDI_CMD_MODE_SET) & (BA_I == 2'h0);
    wire is_read = cmd_en & (cmd == `SDI_CMD_READ);
    wire is_write = cmd_en & (cmd == `SDI_CMD_WRITE);
    wire is_stop = cmd_en & (cmd == `SDI_CMD_TERMINATE);
    wire apb_req = PSEL_I & PENABLE_I;
    wire apb_fire = apb_req & pready_reg;
    wire ctrl_hit = (PADDR_I == `SDI_REG_CTRL);
    wire enforce_clear = apb_fire & PWRITE_I & ctrl_hit & PWDATA_I[`SDI_CTRL_CLEAR];
    wire [2:0] new_bl = ADDR_I[`SDI_MODE_BL_HI:`SDI_MODE_BL_LO];
    wire [2:0] new_lat = ADDR_I[`SDI_MODE_LAT_HI:`SDI_MODE_LAT_LO];
    wire bl_bad = (new_bl > `SDI_BL_8) & (new_bl != `SDI_BL_PAGE);
    wire page_inter = (new_bl == `SDI_BL_PAGE) & ADDR_I[`SDI_MODE_ORDER];
    wire lat_bad = (new_lat != `SDI_LAT_2) & (new_lat != `SDI_LAT_3);
    wire high_bad = (ADDR_I[11:10] != 2'h0);
    wire op_bad = (ADDR_I[`SDI_MODE_OP_HI:`SDI_MODE_OP_LO] != 2'h0);
    wire [2:0] bl_code = mode_reg[`SDI_MODE_BL_HI:`SDI_MODE_BL_LO];
    wire order_bit = mode_reg[`SDI_MODE_ORDER];
    wire [2:0] lat_code = mode_reg[`SDI_MODE_LAT_HI:`SDI_MODE_LAT_LO];
    wire wbo_bit = mode_reg[`SDI_MODE_WBO];
    // reserved latency codes fall back to the slower setting
    wire lat_two = (lat_code == `SDI_LAT_2);
    wire page_burst = (bl_code == `SDI_BL_PAGE);
    reg [10:0] bl_mask, col_in;
    // block base kept from the start column, offset wraps inside the mask
    function [10:0] sdi_col;
        input [10:0] st;
        input [10:0] idx;
        input [10:0] mask;
        input inter;
        reg [10:0] off;
        begin
            off = inter ? (st ^ idx) : (st + idx);
            sdi_col = (st & ~mask) | (off & mask);
        end
    endfunction
    always @* begin
        case (bl_code)
            `SDI_BL_1: bl_mask = 11'h000;
            `SDI_BL_2: bl_mask = 11'h001;
            `SDI_BL_4: bl_mask = 11'h003;
            `SDI_BL_8: bl_mask = 11'h007;
            `SDI_BL_PAGE: bl_mask = PAGE_MASK;
            default: bl_mask = 11'h000;
        endcase
        case (`SDI_ORG)
            2'h0: col_in = {ADDR_I[11], ADDR_I[9:0]};
            2'h1: col_in = {1'h0, ADDR_I[9:0]};
            default: col_in = {2'h0, ADDR_I[8:0]};
        endcase
    end

    // init sequence tracking; the controller owns the order, we only watch
    always @* begin
        phase_next = phase_reg;
        pw_cnt_next = pw_cnt_reg;
        seen_nop_next = seen_nop_reg;
        ref_cnt_next = ref_cnt_reg;
        loaded_next = loaded_reg;
        mode_next = mode_reg;
        // the clear acts first, so an event in the same cycle sets the flag again
        viol_next = enforce_clear ? 1'h0 : viol_reg;
        mode_err_next = enforce_clear ? 1'h0 : mode_err_reg;
        done_next = done_reg;
        busy_next = (busy_reg != 3'h0) ? busy_reg - 3'h1 : 3'h0;
        if (~is_nop && busy_reg != 3'h0) begin
            viol_next = 1'h1;
        end
        if (is_refresh) begin
            busy_next = REF_CYC;
            if (ref_cnt_reg != 4'hF) begin
                ref_cnt_next = ref_cnt_reg + 4'h1;
            end
        end
        if (is_mset) begin
            mode_next = ADDR_I;
            loaded_next = 1'h1;
            busy_next = MSET_CYC;
            if (active_reg || phase_reg == PH_POWER || phase_reg == PH_PRECHARGE) begin
                viol_next = 1'h1;
            end
            if (high_bad | op_bad | bl_bad | page_inter | lat_bad) begin
                mode_err_next = 1'h1;
            end
        end
        case (phase_reg)
            PH_POWER: begin
                if (pw_cnt_reg != PWR_CYC) begin
                    pw_cnt_next = pw_cnt_reg + 12'h001;
                end
                if (is_nop) begin
                    seen_nop_next = 1'h1;
                end
                if (is_pre_all && pw_cnt_reg == PWR_CYC && seen_nop_reg) begin
                    phase_next = PH_PRECHARGE;
                    busy_next = PRE_CYC;
                end else if (~is_nop) begin
                    viol_next = 1'h1;
                end
            end
            PH_PRECHARGE: begin
                if (busy_reg == 3'h0 && is_nop) begin
                    phase_next = PH_IDLE;
                end
            end
            PH_IDLE: begin
                if (~is_nop && ~is_refresh && ~is_mset) begin
                    viol_next = 1'h1;
                end
                if (ref_cnt_reg >= `SDI_MIN_REFRESHES && loaded_reg &&
                    busy_reg == 3'h0 && is_nop) begin
                    phase_next = PH_READY;
                    done_next = 1'h1;
                end
            end
            PH_READY: phase_next = PH_READY;
            default: phase_next = PH_POWER;
        endcase
    end
    // burst column sequencer and read data enable pipeline
    wire start_ok = ~enforce_reg | done_reg;
    wire start_burst = (is_read | is_write) & start_ok & ~is_mset;
    wire single_wr = is_write & wbo_bit;
    wire [10:0] start_mask = single_wr ? 11'h000 : bl_mask;
    always @* begin
        active_next = active_reg;
        is_read_next = is_read_reg;
        full_next = full_reg;
        inter_next = inter_reg;
        start_next = start_reg;
        mask_next = mask_reg;
        idx_next = idx_reg;
        col_next = col_reg;
        col_valid_next = 1'h0;
        col_write_next = 1'h0;
        rd_beat_next = 1'h0;
        rd_pipe_next = rd_beat_reg;
        dq_oe_next = lat_two ? rd_beat_reg : rd_pipe_reg;
        if (start_burst) begin
            start_next = col_in;
            mask_next = start_mask;
            // full page is sequential only
            inter_next = order_bit & ~page_burst;
            full_next = page_burst & ~single_wr;
            is_read_next = is_read;
            active_next = (start_mask != 11'h000);
            idx_next = 11'h001;
            col_next = col_in;
            col_valid_next = 1'h1;
            col_write_next = is_write;
            rd_beat_next = is_read;
            if (is_write) begin
                rd_pipe_next = 1'h0;
                dq_oe_next = 1'h0;
            end
        end else if (is_stop || is_pre || is_mset) begin
            active_next = 1'h0;
        end else if (active_reg) begin
            col_next = sdi_col(start_reg, idx_reg, mask_reg, inter_reg);
            col_valid_next = 1'h1;
            col_write_next = ~is_read_reg;
            rd_beat_next = is_read_reg;
            idx_next = idx_reg + 11'h001;
            if (~full_reg && idx_reg == mask_reg) begin
                active_next = 1'h0;
            end
        end
        if (is_mset) begin
            rd_pipe_next = 1'h0;
            dq_oe_next = 1'h0;
        end
    end
    // apb slave with one wait state; writes land on the completing edge
    always @* begin
        enforce_next = enforce_reg;
        pready_next = apb_req & ~pready_reg;
        prdata_next = 32'h00000000;
        pslverr_next = 1'h0;
        if (apb_req && ~pready_reg) begin
            case (PADDR_I)
                `SDI_REG_STATUS: prdata_next = {20'h00000, seen_nop_reg, active_reg,
                                                mode_err_reg, viol_reg, ref_cnt_reg,
                                                done_reg, loaded_reg, phase_reg};
                `SDI_REG_MODE: prdata_next = {20'h00000, mode_reg};
                `SDI_REG_CTRL: prdata_next = {31'h00000000, enforce_reg};
                default: pslverr_next = 1'h1;
            endcase
        end
        if (apb_fire && PWRITE_I && ctrl_hit) begin
            enforce_next = PWDATA_I[`SDI_CTRL_ENFORCE];
        end
    end

    always @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            phase_reg <= PH_POWER;
            pw_cnt_reg <= 12'h000;
            seen_nop_reg <= 1'h0;
            busy_reg <= 3'h0;
            ref_cnt_reg <= 4'h0;
            loaded_reg <= 1'h0;
            mode_reg <= `SDI_MODE_RESET;
            viol_reg <= 1'h0;
            mode_err_reg <= 1'h0;
            enforce_reg <= `SDI_CTRL_RESET;
            active_reg <= 1'h0;
            is_read_reg <= 1'h0;
            full_reg <= 1'h0;
            inter_reg <= 1'h0;
            start_reg <= 11'h000;
            mask_reg <= 11'h000;
            idx_reg <= 11'h000;
            col_reg <= 11'h000;
            col_valid_reg <= 1'h0;
            col_write_reg <= 1'h0;
            rd_beat_reg <= 1'h0;
            rd_pipe_reg <= 1'h0;
            dq_oe_reg <= 1'h0;
            done_reg <= 1'h0;
            prdata_reg <= 32'h00000000;
            pready_reg <= 1'h0;
            pslverr_reg <= 1'h0;
        end else begin
            phase_reg <= phase_next;
            pw_cnt_reg <= pw_cnt_next;
            seen_nop_reg <= seen_nop_next;
            busy_reg <= busy_next;
            ref_cnt_reg <= ref_cnt_next;
            loaded_reg <= loaded_next;
            mode_reg <= mode_next;
            viol_reg <= viol_next;
            mode_err_reg <= mode_err_next;
            enforce_reg <= enforce_next;
            active_reg <= active_next;
            is_read_reg <= is_read_next;
            full_reg <= full_next;
            inter_reg <= inter_next;
            start_reg <= start_next;
            mask_reg <= mask_next;
            idx_reg <= idx_next;
            col_reg <= col_next;
            col_valid_reg <= col_valid_next;
            col_write_reg <= col_write_next;
            rd_beat_reg <= rd_beat_next;
            rd_pipe_reg <= rd_pipe_next;
            dq_oe_reg <= dq_oe_next;
            done_reg <= done_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end
    assign PRDATA_O = prdata_reg;
    assign PREADY_O = pready_reg;
    assign PSLVERR_O = pslverr_reg;
    assign COL_ADDR_O = col_reg;
    assign COL_VALID_O = col_valid_reg;
    assign COL_WRITE_O = col_write_reg;
    assign DQ_OE_O = dq_oe_reg;
    assign INIT_DONE_O = done_reg;
endmodule

// [sim/sdi_ctrl_model.sv]
// controller-side model: drives the power-up sequence and memory commands
`timescale 1ns/1ps
`include "sdi_defs.vh"

module sdi_ctrl_model (
    input wire clk_i,
    output logic cke_o,
    output logic cs_n_o,
    output logic ras_n_o,
    output logic cas_n_o,
    output logic we_n_o,
    output logic [1:0] ba_o,
    output logic [11:0] addr_o
);
    initial begin
        cke_o = 1'b0;
        cs_n_o = 1'b1;
        {ras_n_o, cas_n_o, we_n_o} = `SDI_CMD_NOP;
        ba_o = 2'h0;
        addr_o = 12'h000;
    end

    task issue(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a);
        begin
            @(posedge clk_i);
            cs_n_o <= 1'b0;
            {ras_n_o, cas_n_o, we_n_o} <= c;
            ba_o <= b;
            addr_o <= a;
        end
    endtask

    // bank and address lines toggle while deselected so a stale value cannot pass for a driven one
    task idle(input int n);
        begin
            repeat (n) begin
                @(posedge clk_i);
                cs_n_o <= 1'b1;
                {ras_n_o, cas_n_o, we_n_o} <= `SDI_CMD_NOP;
                ba_o <= ~ba_o;
                addr_o <= ~addr_o;
            end
        end
    endtask

    task power_up(input logic stray, input logic [11:0] mode);
        begin
            repeat (8) @(posedge clk_i);
            cke_o <= 1'b1;
            issue(`SDI_CMD_NOP, 2'h0, 12'h000);
            // early read only when the bench asks for an out-of-order command
            if (stray)
                issue(`SDI_CMD_READ, 2'h0, 12'h005);
            idle(1010);
            issue(`SDI_CMD_PRECHARGE, 2'h0, 12'h400);
            idle(2);
            repeat (3) begin
                issue(`SDI_CMD_REFRESH, 2'h0, 12'h000);
                idle(2);
            end
            issue(`SDI_CMD_MODE_SET, 2'h0, mode);
            idle(4);
        end
    endtask
endmodule

// [sim/sdi_init_props.sv]
// assertion checker for the sdram init tracker ports
`timescale 1ns/1ps
`include "sdi_defs.vh"

module sdi_init_props (
    input wire CLK_I,
    input wire RESET_N_I,
    input wire CKE_I,
    input wire CS_N_I,
    input wire RAS_N_I,
    input wire CAS_N_I,
    input wire WE_N_I,
    input wire [1:0] BA_I,
    input wire [11:0] ADDR_I,
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire [31:0] PRDATA_O,
    input wire PREADY_O,
    input wire PSLVERR_O,
    input wire [10:0] COL_ADDR_O,
    input wire COL_VALID_O,
    input wire COL_WRITE_O,
    input wire DQ_OE_O,
    input wire INIT_DONE_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);
    logic [11:0] mode_q;
    wire [2:0] cmd = {RAS_N_I, CAS_N_I, WE_N_I};
    wire live = CKE_I && !CS_N_I;
    wire nop_c = !live || cmd == `SDI_CMD_NOP;
    wire ms_c = live && cmd == `SDI_CMD_MODE_SET && BA_I == 2'h0;
    wire rw_c = live && INIT_DONE_O && (cmd == `SDI_CMD_READ || cmd == `SDI_CMD_WRITE);
    wire [10:0] col_in = {1'b0, ADDR_I[9:0]};
    wire [10:0] msk = {1'b0, 10'((11'h1 << mode_q[2:0]) - 11'h1)};

    // shadow of the mode word, so burst checks know the programmed shape
    always @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I)
            mode_q <= `SDI_MODE_RESET;
        else if (ms_c)
            mode_q <= ADDR_I;
    end

    function automatic logic [10:0] next_col(input logic [10:0] a);
        logic [10:0] n;
        begin
            n = mode_q[3] ? (a ^ 11'h1) : (a + 11'h1);
            next_col = (a & ~msk) | (n & msk);
        end
    endfunction

    sequence s_fixed_rw;
        rw_c && mode_q[2:0] != 3'h0 && mode_q[2:0] < 3'h4 && !(!WE_N_I && mode_q[9]);
    endsequence
    sequence s_rd_cl2;
        rw_c && WE_N_I && mode_q[6:4] == `SDI_LAT_2;
    endsequence
    sequence s_rd_cl3;
        rw_c && WE_N_I && mode_q[6:4] == `SDI_LAT_3;
    endsequence

    property p_ready;
        PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O;
    endproperty
    property p_pulse;
        PREADY_O |=> !PREADY_O;
    endproperty
    property p_err;
        PSLVERR_O |-> PREADY_O && PRDATA_O == 32'h0;
    endproperty
    property p_beat0;
        rw_c |=> COL_VALID_O && COL_ADDR_O == $past(col_in) && COL_WRITE_O == !$past(WE_N_I);
    endproperty
    property p_beat1;
        s_fixed_rw ##1 nop_c |=> COL_VALID_O && COL_ADDR_O == next_col($past(col_in, 2));
    endproperty
    property p_wbo;
        rw_c && !WE_N_I && mode_q[9] ##1 nop_c |=> !COL_VALID_O;
    endproperty
    property p_cl2;
        s_rd_cl2 ##1 nop_c |=> DQ_OE_O;
    endproperty
    property p_cl3;
        s_rd_cl3 ##1 nop_c ##1 nop_c |=> DQ_OE_O;
    endproperty
    property p_ms_hiz;
        ms_c |=> !DQ_OE_O;
    endproperty
    property p_page;
        COL_VALID_O && COL_ADDR_O == 11'h3FF && mode_q[2:0] == `SDI_BL_PAGE && nop_c
            && !(COL_WRITE_O && mode_q[9]) |=> COL_VALID_O && COL_ADDR_O == 11'h000;
    endproperty

    a_ready: assert property (p_ready) else $error("ready not raised after access");
    a_pulse: assert property (p_pulse) else $error("ready held over one cycle");
    a_err: assert property (p_err) else $error("error response malformed");
    a_beat0: assert property (p_beat0) else $error("first beat column wrong");
    a_beat1: assert property (p_beat1) else $error("second beat column wrong");
    a_wbo: assert property (p_wbo) else $error("write burst not single");
    a_cl2: assert property (p_cl2) else $error("latency two output late");
    a_cl3: assert property (p_cl3) else $error("latency three output late");
    a_ms_hiz: assert property (p_ms_hiz) else $error("outputs driven after mode set");
    a_page: assert property (p_page) else $error("full page did not wrap");
endmodule

bind sdi_init_mode sdi_init_props u_props (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I),
    .CKE_I(CKE_I), .CS_N_I(CS_N_I), .RAS_N_I(RAS_N_I), .CAS_N_I(CAS_N_I), .WE_N_I(WE_N_I),
    .BA_I(BA_I), .ADDR_I(ADDR_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
    .COL_ADDR_O(COL_ADDR_O), .COL_VALID_O(COL_VALID_O), .COL_WRITE_O(COL_WRITE_O),
    .DQ_OE_O(DQ_OE_O), .INIT_DONE_O(INIT_DONE_O));

// [sim/tb.sv]
// self-checking bench: power-up sequence, burst orders and register access
`timescale 1ns/1ps
`include "sdi_defs.vh"

module tb;
    logic clk, reset_n, psel, penable, pwrite, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, col_valid, col_write, dq_oe, init_done;
    logic cke, cs_n, ras_n, cas_n, we_n;
    logic [1:0] ba;
    logic [11:0] addr;
    logic [10:0] col_addr;
    logic [10:0] beats [0:63];
    int nb, ndq, n_errors, samples_checked;

    sdi_ctrl_model m_ctl (.clk_i(clk), .cke_o(cke), .cs_n_o(cs_n), .ras_n_o(ras_n),
        .cas_n_o(cas_n), .we_n_o(we_n), .ba_o(ba), .addr_o(addr));
    sdi_init_mode DUT (.CLK_I(clk), .RESET_N_I(reset_n), .CKE_I(cke), .CS_N_I(cs_n),
        .RAS_N_I(ras_n), .CAS_N_I(cas_n), .WE_N_I(we_n), .BA_I(ba), .ADDR_I(addr),
        .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .COL_ADDR_O(col_addr), .COL_VALID_O(col_valid), .COL_WRITE_O(col_write),
        .DQ_OE_O(dq_oe), .INIT_DONE_O(init_done));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        if (col_valid === 1'b1 && nb < 64) begin
            beats[nb] = col_addr;
            nb = nb + 1;
        end
        if (dq_oe === 1'b1)
            ndq = ndq + 1;
    end

    task final_report;
        begin
            if (n_errors == 0 && samples_checked > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                $display("MISMATCH %s expected %h seen %h", what, exp, got);
                n_errors = n_errors + 1;
            end
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        begin
            @(posedge clk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            penable <= 1'b1;
            i = 0;
            do begin
                @(posedge clk);
                i = i + 1;
            end while (pready !== 1'b1 && i < 16);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            if (pready !== 1'b1) begin
                n_errors = n_errors + 1;
                final_report;
            end
        end
    endtask

    task rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        begin
            apb(1'b0, a, 32'h0);
            chk(what, exp, rd);
        end
    endtask

    // program the mode word, run one access and compare the column sequence
    task burst(input logic [11:0] m, input logic [2:0] c, input logic [9:0] s);
        int n, k, b0, d0;
        logic page;
        logic [9:0] msk, e;
        begin
            page = (m[2:0] == `SDI_BL_PAGE);
            m_ctl.issue(`SDI_CMD_MODE_SET, 2'h0, m);
            m_ctl.idle(1);
            b0 = nb;
            d0 = ndq;
            m_ctl.issue(c, 2'h0, {2'h0, s});
            if (page) begin
                m_ctl.idle(3);
                m_ctl.issue(`SDI_CMD_TERMINATE, 2'h0, 12'h000);
            end
            m_ctl.idle(12);
            n = (c == `SDI_CMD_WRITE && m[9]) ? 1 : (page ? 4 : (1 << m[2:0]));
            msk = page ? 10'h3FF : 10'(n - 1);
            if (page)
                chk("page stop", 32'h1, {31'h0, nb - b0 > 3 && nb - b0 < 8});
            else
                chk("beat count", n, nb - b0);
            if (!page)
                chk("drive count", (c == `SDI_CMD_READ) ? n : 0, ndq - d0);
            for (k = 0; k < n; k++) begin
                e = (s & ~msk) | ((m[3] ? s ^ k[9:0] : s + k[9:0]) & msk);
                chk("column", {22'h0, e}, {21'h0, beats[b0 + k]});
            end
        end
    endtask

    initial begin
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        n_errors = 0;
        samples_checked = 0;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        rdchk("ctrl", `SDI_REG_CTRL, 32'h0);
        rdchk("mode", `SDI_REG_MODE, 32'h0);
        apb(1'b1, `SDI_REG_CTRL, 32'h1);
        m_ctl.power_up(1'b1, 12'h022);
        chk("refused beats", 32'h0, nb);
        chk("init done", 32'h1, {31'h0, init_done});
        rdchk("status", `SDI_REG_STATUS, 32'h93F);
        apb(1'b1, `SDI_REG_CTRL, 32'h3);
        rdchk("status", `SDI_REG_STATUS, 32'h83F);
        rdchk("mode", `SDI_REG_MODE, 32'h022);
        burst(12'h028, `SDI_CMD_READ, 10'h155);
        burst(12'h039, `SDI_CMD_READ, 10'h003);
        burst(12'h022, `SDI_CMD_READ, 10'h001);
        burst(12'h02A, `SDI_CMD_READ, 10'h005);
        burst(12'h033, `SDI_CMD_READ, 10'h3FD);
        burst(12'h03B, `SDI_CMD_READ, 10'h0A6);
        burst(12'h233, `SDI_CMD_WRITE, 10'h012);
        burst(12'h022, `SDI_CMD_WRITE, 10'h011);
        burst(12'h027, `SDI_CMD_READ, 10'h3FE);
        m_ctl.issue(`SDI_CMD_MODE_SET, 2'h1, 12'h030);
        m_ctl.idle(2);
        rdchk("mode", `SDI_REG_MODE, 32'h027);
        m_ctl.issue(`SDI_CMD_MODE_SET, 2'h0, 12'h0AF);
        m_ctl.idle(2);
        rdchk("status", `SDI_REG_STATUS, 32'hA3F);
        apb(1'b1, `SDI_REG_CTRL, 32'h3);
        rdchk("status", `SDI_REG_STATUS, 32'h83F);
        apb(1'b0, 8'h0C, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        final_report;
    end
endmodule
